// ===== hw/cnfec_node.v
// Purpose: can slave node frame acceptance, arbitration and error state
// Assumes: a bit-level controller outside delivers decoded frames and events
// Notes: all outputs are registered
// How it works
// R1 - accept standard ids, drop extended frames
// R2 - data frame: id plus zero to eight bytes
// R3 - remote frame for our id triggers reply
// R4 - smallest identifier wins arbitration
// R5 - errors raise counters, successes lower them
// R6 - low counters: error active, flags errors
// R7 - counter at warning limit: warning flag
// R8 - passive: stop flagging others' errors
// R9 - bus off: no transmit, no receive
// R10 - node address 1 to 127, unique
// R11 - multibyte values least significant byte first
// R12 - id split: function bits 10-7, address 6-0
// R13 - limits 96, 128, transmit above 255
`timescale 1ns/10ps
`include "cnfec_regs.vh"
module cnfec_node (
	input wire i_ref_clk,
	input wire i_rstn,
	input wire [6:0] i_node_address_setting,
	input wire i_rx_valid,
	input wire i_rx_ext,
	input wire i_rx_remote,
	input wire [`CNFEC_ID_W-1:0] i_rx_id,
	input wire [3:0] i_rx_len,
	input wire [63:0] i_rx_data,
	input wire i_tx_req,
	input wire [`CNFEC_ID_W-1:0] i_tx_id,
	input wire [3:0] i_tx_len,
	input wire [63:0] i_tx_data,
	input wire [3:0] i_reply_func,
	input wire [3:0] i_reply_len,
	input wire [63:0] i_reply_data,
	input wire i_bus_req,
	input wire [`CNFEC_ID_W-1:0] i_bus_id,
	input wire i_tx_done,
	input wire i_tx_err,
	input wire i_rx_err,
	input wire i_rx_err_own,
	input wire i_bus_off_reset,
	output reg o_rx_valid,
	output reg o_rx_remote,
	output reg [3:0] o_rx_func,
	output reg [6:0] o_rx_addr,
	output reg [3:0] o_rx_len,
	output reg [63:0] o_rx_data,
	output reg o_tx_start,
	output reg [`CNFEC_ID_W-1:0] o_tx_id,
	output reg [3:0] o_tx_len,
	output reg [63:0] o_tx_data,
	output reg o_err_flag,
	output reg o_warning,
	output reg o_err_passive,
	output reg o_bus_off,
	output reg o_addr_ok,
	output reg [8:0] o_tec,
	output reg [8:0] o_rec
);
	////////////////////////////////////////////////////////////////////////////////
	localparam ST_ACTIVE = 3'b001;
	localparam ST_PASSIVE = 3'b010;
	localparam ST_OFF = 3'b100;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [6:0] addr_meta;
	reg [6:0] addr;
	reg reply_pend;
	wire [8:0] tec;
	wire [8:0] rec;
	wire own_wins;
	wire rx_take;
	wire addr_valid;
	wire want_tx;
	wire [`CNFEC_ID_W-1:0] want_id;
	wire [3:0] rlen;
	wire [3:0] tlen;

	// length field may read up to 15; clamp to the eight-byte data field
	function [3:0] clamp_len;
		input [3:0] len;
		begin
			clamp_len = (len > `CNFEC_MAX_BYTES) ? `CNFEC_MAX_BYTES : len; // [R2]
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	assign addr_valid = (addr >= `CNFEC_ADDR_MIN) && (addr <= `CNFEC_ADDR_MAX); // [R10]
	// extended frames and everything while bus off are dropped
	assign rx_take = i_rx_valid && !i_rx_ext && (state != ST_OFF); // [R1] [R9]
	assign rlen = clamp_len(i_rx_len);
	assign tlen = clamp_len(i_tx_len);
	// a pending remote reply outranks a fresh local request
	assign want_tx = (reply_pend || i_tx_req) && (state != ST_OFF) && addr_valid; // [R9]
	assign want_id = reply_pend ? {i_reply_func, addr} : i_tx_id; // [R12]

	cnfec_arb u_arb (
		.i_own_id(want_id),
		.i_own_req(want_tx),
		.i_bus_id(i_bus_id),
		.i_bus_req(i_bus_req),
		.o_own_wins(own_wins)
	);

	cnfec_errcnt u_tec (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_clear(state == ST_OFF && i_bus_off_reset),
		.i_err(i_tx_err && state != ST_OFF),
		.i_ok(i_tx_done && state != ST_OFF),
		.i_step(`CNFEC_ERR_INC),
		.o_count(tec)
	);

	cnfec_errcnt u_rec (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_clear(state == ST_OFF && i_bus_off_reset),
		.i_err(i_rx_err && state != ST_OFF),
		.i_ok(rx_take),
		.i_step(`CNFEC_RX_INC),
		.o_count(rec)
	);

	////////////////////////////////////////////////////////////////////////////////
	// error state from counters
	always @* begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (tec > `CNFEC_OFF_LIM) begin
					next_state = ST_OFF; // [R13]
				end else if (tec >= `CNFEC_PASS_LIM || rec >= `CNFEC_PASS_LIM) begin
					next_state = ST_PASSIVE; // [R8] [R13]
				end
			end
			ST_PASSIVE: begin
				if (tec > `CNFEC_OFF_LIM) begin
					next_state = ST_OFF; // [R9] [R13]
				end else if (tec < `CNFEC_PASS_LIM && rec < `CNFEC_PASS_LIM) begin
					next_state = ST_ACTIVE; // [R6]
				end
			end
			ST_OFF: begin
				// leaves only on an explicit recovery request
				if (i_bus_off_reset) begin
					next_state = ST_ACTIVE;
				end
			end
			default: begin
				next_state = ST_ACTIVE;
			end
		endcase
	end

	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= ST_ACTIVE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// address strap comes from pins: two flops before any logic reads it
	// only the second flop feeds the decode, so a switch change mid-edge is safe
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			addr_meta <= 7'h00;
			addr <= 7'h00;
		end else begin
			addr_meta <= i_node_address_setting;
			addr <= addr_meta; // [R10]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive path
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rx_valid <= 1'b0;
			o_rx_remote <= 1'b0;
			o_rx_func <= 4'h0;
			o_rx_addr <= 7'h00;
			o_rx_len <= 4'h0;
			o_rx_data <= 64'h0;
			reply_pend <= 1'b0;
		end else begin
			o_rx_valid <= rx_take; // [R1]
			if (rx_take) begin
				o_rx_remote <= i_rx_remote;
				o_rx_func <= i_rx_id[`CNFEC_FUNC_MSB:`CNFEC_FUNC_LSB]; // [R12]
				o_rx_addr <= i_rx_id[`CNFEC_ADDR_MSB:`CNFEC_ADDR_LSB]; // [R12]
				// remote frames carry no data field
				o_rx_len <= i_rx_remote ? 4'h0 : rlen; // [R3] [R2]
				// byte 0 in bits 7:0, so lsb-first values land in place
				o_rx_data <= i_rx_remote ? 64'h0 : i_rx_data; // [R11]
			end
			// a new remote request for our reply object wins over the clear
			if (rx_take && i_rx_remote && addr_valid &&
				i_rx_id == {i_reply_func, addr}) begin
				reply_pend <= 1'b1; // [R3]
			end else if (own_wins && reply_pend) begin
				reply_pend <= 1'b0;
			end else if (state == ST_OFF) begin
				reply_pend <= 1'b0; // [R9]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit path; a lost arbitration simply retries next cycle
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_tx_start <= 1'b0;
			o_tx_id <= 11'h000;
			o_tx_len <= 4'h0;
			o_tx_data <= 64'h0;
		end else begin
			o_tx_start <= own_wins; // [R4] [R9]
			if (own_wins) begin
				o_tx_id <= want_id;
				o_tx_len <= reply_pend ? clamp_len(i_reply_len) : tlen; // [R3]
				o_tx_data <= reply_pend ? i_reply_data : i_tx_data; // [R11]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status and error signalling
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_err_flag <= 1'b0;
			o_warning <= 1'b0;
			o_err_passive <= 1'b0;
			o_bus_off <= 1'b0;
			o_addr_ok <= 1'b0;
			o_tec <= 9'h000;
			o_rec <= 9'h000;
		end else begin
			// passive nodes only flag errors in their own frames
			o_err_flag <= (state == ST_ACTIVE && (i_rx_err || i_tx_err)) || // [R6]
				(state == ST_PASSIVE && (i_tx_err || i_rx_err_own)); // [R8]
			o_warning <= (state != ST_OFF) &&
				(tec >= `CNFEC_WARN_LIM || rec >= `CNFEC_WARN_LIM); // [R7] [R13]
			o_err_passive <= (state == ST_PASSIVE); // [R8]
			o_bus_off <= (state == ST_OFF); // [R9]
			o_addr_ok <= addr_valid; // [R10]
			o_tec <= tec;
			o_rec <= rec;
		end
	end
endmodule // cnfec_node

// ===== hw/cnfec_regs.vh
// Purpose: constants for the can node frame and error control block
// Assumes: 11-bit identifiers, counters 9 bits wide
// Notes: included by every design file
`ifndef CNFEC_REGS_VH
`define CNFEC_REGS_VH
`define CNFEC_ID_W 11
`define CNFEC_FUNC_MSB 10
`define CNFEC_FUNC_LSB 7
`define CNFEC_ADDR_MSB 6
`define CNFEC_ADDR_LSB 0
`define CNFEC_MAX_BYTES 4'h8
`define CNFEC_ADDR_MIN 7'h01
`define CNFEC_ADDR_MAX 7'h7f
`define CNFEC_WARN_LIM 9'h060
`define CNFEC_PASS_LIM 9'h080
`define CNFEC_OFF_LIM 9'h0ff
`define CNFEC_ERR_INC 9'h008
`define CNFEC_RX_INC 9'h001
`endif

// ===== hw/cnfec_arb.v
// Purpose: identifier arbitration among contending frames
// Assumes: all contenders present in the same cycle
// Notes: smallest identifier wins
`timescale 1ns/10ps
`include "cnfec_regs.vh"
module cnfec_arb (
	input wire [`CNFEC_ID_W-1:0] i_own_id,
	input wire i_own_req,
	input wire [`CNFEC_ID_W-1:0] i_bus_id,
	input wire i_bus_req,
	output wire o_own_wins
);
	// ties go to us: same id means same frame on a sane bus
	assign o_own_wins = i_own_req && (!i_bus_req || (i_own_id <= i_bus_id)); // [R4]
endmodule // cnfec_arb

// ===== hw/cnfec_errcnt.v
// Purpose: one saturating error counter
// Assumes: one event per cycle at most
// Notes: error step wins over success step
`timescale 1ns/10ps
`include "cnfec_regs.vh"
module cnfec_errcnt (
	input wire i_ref_clk,
	input wire i_rstn,
	input wire i_clear,
	input wire i_err,
	input wire i_ok,
	input wire [8:0] i_step,
	output reg [8:0] o_count
);
	wire [9:0] sum;
	assign sum = {1'b0, o_count} + {1'b0, i_step};
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_count <= 9'h000;
		end else if (i_clear) begin
			o_count <= 9'h000;
		end else if (i_err) begin
			o_count <= sum[9] ? 9'h1ff : sum[8:0]; // [R5]
		end else if (i_ok && o_count != 9'h000) begin
			o_count <= o_count - 9'h001; // [R5]
		end
	end
endmodule // cnfec_errcnt

// ===== dv/cnfec_node_asserts.sv
// Purpose: port checker for cnfec_node
// Assumes: lags of counters, state and flags as handed over
// Notes: bound below; flags read one edge behind o_tec, except o_warning on the same edge in a_low_quiet
`timescale 1ns/10ps
module cnfec_node_asserts (
	input wire i_ref_clk,
	input wire i_rstn,
	input wire i_rx_valid,
	input wire i_rx_ext,
	input wire [10:0] i_rx_id,
	input wire [10:0] i_tx_id,
	input wire i_bus_req,
	input wire [10:0] i_bus_id,
	input wire i_tx_done,
	input wire i_tx_err,
	input wire i_rx_err,
	input wire i_rx_err_own,
	input wire i_bus_off_reset,
	input wire o_rx_valid,
	input wire [3:0] o_rx_func,
	input wire [6:0] o_rx_addr,
	input wire o_tx_start,
	input wire o_warning,
	input wire o_err_passive,
	input wire o_bus_off,
	input wire [8:0] o_tec,
	input wire [8:0] o_rec
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	a_ext_drop: assert property (i_rx_valid && i_rx_ext |=> !o_rx_valid)
		else $error("extended frame accepted");
	a_std_take: assert property (i_rx_valid && !i_rx_ext && o_tec < 9'h0c0
		|=> o_rx_valid && {o_rx_func, o_rx_addr} == $past(i_rx_id)) else $error("frame lost");
	a_off_quiet: assert property (o_bus_off |-> !o_rx_valid && !o_tx_start)
		else $error("traffic while bus off");
	a_warn_level: assert property ((o_tec >= 9'h060 || o_rec >= 9'h060) && o_tec <= 9'h0ff
		&& !$past(i_bus_off_reset) |=> o_warning) else $error("warning missing");
	a_pass_level: assert property ((o_tec >= 9'h080 || o_rec >= 9'h080) && o_tec <= 9'h0ff
		&& !$past(i_bus_off_reset) |=> o_err_passive) else $error("passive missing");
	a_off_level: assert property (o_tec > 9'h0ff && !$past(i_bus_off_reset) |=> o_bus_off)
		else $error("bus off missing");
	a_low_quiet: assert property (o_tec < 9'h060 && o_rec < 9'h060 |-> !o_warning)
		else $error("warning while low");
	a_tx_step: assert property (i_tx_err && !(i_tx_done || i_rx_err || i_rx_err_own
		|| i_bus_off_reset) && o_tec < 9'h0f8 |=> ##1 o_tec == $past(o_tec) + 9'h008)
		else $error("tec step wrong");
	a_arb_lose: assert property (i_bus_req && i_bus_id == 11'h000 && i_tx_id != 11'h000
		|=> !o_tx_start) else $error("lost arbitration ignored");
endmodule // cnfec_node_asserts
bind cnfec_node cnfec_node_asserts u_cnfec_node_asserts (.*);

// ===== dv/cnfec_peer.sv
// Purpose: far side that carries each started frame and reports its end
// Assumes: one frame in flight at a time
// Notes: i_lag sets prompt or slow completion
`timescale 1ns/10ps
module cnfec_peer (
	input wire i_ref_clk,
	input wire i_rstn,
	input wire i_start,
	input wire i_fail,
	input wire [3:0] i_lag,
	output reg o_done,
	output reg o_err
);
	reg [4:0] cnt;
	// frame occupies the wire, then done or error pulse
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt <= 5'h00;
			o_done <= 1'b0;
			o_err <= 1'b0;
		end else begin
			o_done <= 1'b0;
			o_err <= 1'b0;
			if (i_start)
				cnt <= {1'b0, i_lag} + 5'h01;
			else if (cnt != 5'h00) begin
				cnt <= cnt - 5'h01;
				o_done <= (cnt == 5'h01) && !i_fail;
				o_err <= (cnt == 5'h01) && i_fail;
			end
		end
	end
endmodule // cnfec_peer

// ===== dv/tb.sv
// Purpose: self-checking bench for cnfec_node
// Assumes: peer model completes every started frame
// Notes: random ids and data from a fixed lfsr
`timescale 1ns/10ps
module tb;
	reg i_ref_clk = 0, i_rstn = 0, i_rx_valid = 0, i_rx_ext = 0, i_rx_remote = 0;
	reg i_tx_req = 0, i_bus_req = 0, i_rx_err = 0, i_rx_err_own = 0, i_bus_off_reset = 0;
	reg fail = 0, got;
	reg [6:0] i_node_address_setting = 7'h05;
	reg [10:0] i_rx_id = 0, i_tx_id = 0, i_bus_id = 0, own, bus;
	reg [3:0] i_rx_len = 0, i_tx_len = 4'h2, i_reply_func = 4'h3, i_reply_len = 4'h4, lag = 2;
	reg [63:0] i_rx_data = 0, i_tx_data = 0, i_reply_data = 64'h1234_5678;
	reg [15:0] lf = 16'h000f;
	wire i_tx_done, i_tx_err, o_rx_valid, o_rx_remote, o_tx_start, o_err_flag;
	wire o_warning, o_err_passive, o_bus_off, o_addr_ok;
	wire [3:0] o_rx_func, o_rx_len, o_tx_len;
	wire [6:0] o_rx_addr;
	wire [10:0] o_tx_id;
	wire [63:0] o_rx_data, o_tx_data;
	wire [8:0] o_tec, o_rec;
	integer fails = 0, check_count = 0, k, j;
	cnfec_node u_cnfec_node (.*);
	cnfec_peer u_cnfec_peer (.i_ref_clk, .i_rstn, .i_start(o_tx_start), .i_fail(fail),
		.i_lag(lag), .o_done(i_tx_done), .o_err(i_tx_err));
	initial forever #10 i_ref_clk = ~i_ref_clk;
	////////////////////////////////////////
	function [15:0] nx(input [15:0] s);
		nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function [3:0] clamp(input [3:0] n);
		clamp = (n > 4'h8) ? 4'h8 : n;
	endfunction
	task chk(input string n, input [63:0] e, input [63:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("CHECK FAILED %0s exp %h got %h", n, e, g);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task rx(input ext, input rem, input [10:0] id, input [63:0] d);
		@(posedge i_ref_clk);
		i_rx_valid <= 1'b1;
		i_rx_ext <= ext;
		i_rx_remote <= rem;
		i_rx_id <= id;
		i_rx_len <= lf[3:0];
		i_rx_data <= d;
		@(posedge i_ref_clk);
		i_rx_valid <= 1'b0;
		#1;
	endtask
	// request held until start seen or 12 edges pass, released before the next edge
	task send(input [10:0] id);
		@(posedge i_ref_clk);
		i_tx_req <= 1'b1;
		i_tx_id <= id;
		i_tx_data <= {4{lf}};
		got = 0;
		for (k = 0; k < 12 && !got; k = k + 1) begin
			@(posedge i_ref_clk);
			#1;
			got = o_tx_start;
		end
		i_tx_req <= 1'b0;
		cyc(lag + 7);
	endtask
	task pulse_rx_err;
		@(posedge i_ref_clk);
		i_rx_err <= 1'b1;
		@(posedge i_ref_clk);
		i_rx_err <= 1'b0;
	endtask
	task summarize;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge i_ref_clk);
		fails = fails + 1;
		summarize;
	end
	initial begin
		cyc(3);
		i_rstn <= 1'b1;
		cyc(3);
		chk("addr_ok", 1, o_addr_ok);
		for (j = 0; j < 12; j = j + 1) begin
			lf = nx(lf);
			rx(lf[0] || j == 0, 0, lf[10:0], {lf, ~lf, lf, lf});
			chk("rx_valid", !(lf[0] || j == 0), o_rx_valid);
			if (o_rx_valid === 1'b1) chk("rx_id", lf[10:0], {o_rx_func, o_rx_addr});
			if (o_rx_valid === 1'b1) chk("rx_len", clamp(lf[3:0]), o_rx_len);
		end
		rx(0, 0, 11'h205, 64'h0000_ff00_1234_5678);
		chk("byte0", 8'h78, o_rx_data[7:0]);
		rx(0, 1, {4'h3, i_node_address_setting}, 0);
		chk("rx_remote", 1, o_rx_remote);
		chk("remote_len", 0, o_rx_len);
		cyc(1);
		chk("reply_len", 4, o_tx_len);
		chk("reply_start", 1, o_tx_start);
		chk("reply_id", {i_reply_func, 7'h05}, o_tx_id);
		chk("reply_data", i_reply_data, o_tx_data);
		cyc(10);
		i_bus_req <= 1'b1;
		for (j = 0; j < 6; j = j + 1) begin
			lf = nx(lf);
			bus = (j == 0) ? 11'h000 : lf[10:0];
			own = (j == 1) ? bus : (lf[15:5] | 11'h001);
			i_bus_id <= bus;
			send(own);
			chk("arb_win", own <= bus, got);
		end
		i_bus_req <= 1'b0;
		i_node_address_setting <= 7'h00;
		cyc(3);
		chk("addr_ok0", 0, o_addr_ok);
		send(11'h123);
		chk("tx_bad_addr", 0, got);
		i_node_address_setting <= 7'h7f;
		cyc(3);
		chk("addr_ok127", 1, o_addr_ok);
		repeat (3) begin
			pulse_rx_err;
			#1;
			chk("err_flag", 1, o_err_flag);
		end
		cyc(4);
		chk("rec_up", 3, o_rec);
		rx(0, 0, 11'h222, 0);
		cyc(4);
		chk("rec_down", 2, o_rec);
		fail = 1;
		for (j = 1; j <= 32; j = j + 1) begin
			lf = nx(lf);
			lag = {1'b0, lf[2:0]};
			send(11'h300);
			chk("tec", 8 * j, o_tec);
			chk("warn", j >= 12 && j < 32, o_warning);
			if (j < 32) chk("passive", j >= 16, o_err_passive);
			chk("bus_off", j == 32, o_bus_off);
			if (j == 20) begin
				pulse_rx_err;
				#1;
				chk("passive_flag", 0, o_err_flag);
			end
		end
		send(11'h001);
		chk("tx_off", 0, got);
		rx(0, 0, 11'h101, 0);
		chk("rx_off", 0, o_rx_valid);
		@(posedge i_ref_clk);
		i_bus_off_reset <= 1'b1;
		@(posedge i_ref_clk);
		i_bus_off_reset <= 1'b0;
		cyc(4);
		chk("tec_clr", 0, o_tec);
		chk("off_clr", 0, o_bus_off);
		fail = 0;
		send(11'h050);
		chk("tx_again", 1, got);
		summarize;
	end
endmodule // tb
